// *** logic/cis_sequencer.sv ***
// interrupt sequencer: flags, enables, entry/return sequencing, sleep wake
// assumes core, peripherals and apb master run on clk_sys; ext pin async
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps

module cis_sequencer #(
   parameter int NPER = 8,
   parameter logic [NPER-1:0] PER_WAKE_OK = '0
) (
   input wire logic clk_sys,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event sources
   input wire logic timerEvent,
   input wire logic iocAny,
   input wire logic extPin,
   input wire logic [NPER-1:0] perEvent,
   // core side
   input wire logic coreSleep,
   input wire logic returnFromIrq,
   input wire logic [cis_pkg::PC_W-1:0] corePc,
   input wire logic [cis_pkg::W_W-1:0] ctxW,
   input wire logic [cis_pkg::STAT_W-1:0] ctxStatus,
   input wire logic [cis_pkg::BSR_W-1:0] ctxBsr,
   input wire logic [cis_pkg::FSR_W-1:0] ctxFsr0,
   input wire logic [cis_pkg::FSR_W-1:0] ctxFsr1,
   input wire logic [cis_pkg::PCLATH_W-1:0] ctxPclath,
   output logic [1:0] instrPhase,
   output logic flushPrefetch,
   output logic pushPc,
   output logic [cis_pkg::PC_W-1:0] pushAddr,
   output logic loadVector,
   output logic [cis_pkg::PC_W-1:0] vectorAddr,
   output logic popPc,
   output logic restoreCtx,
   output logic wakeUp,
   output logic [cis_pkg::W_W-1:0] shadowW,
   output logic [cis_pkg::STAT_W-1:0] shadowStatus,
   output logic [cis_pkg::BSR_W-1:0] shadowBsr,
   output logic [cis_pkg::FSR_W-1:0] shadowFsr0,
   output logic [cis_pkg::FSR_W-1:0] shadowFsr1,
   output logic [cis_pkg::PCLATH_W-1:0] shadowPclath,
   output logic irq
);
   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   cis_pkg::cis_state_t state;
   logic [1:0] phase;
   logic q1;
   logic global_irq_enable, peripheral_group_enable, tmrEn, extEn, iocEn;
   logic tmrFlag, extFlag, iocFlag;
   logic extEdgeSelect;
   logic [NPER-1:0] perEn, perFlag;
   logic [2:0] slpEn;
   logic [NPER-1:0] slpPerEn;
   logic wakeHold;
   logic extSync1, extSync2, extPrev, extEdge;
   logic [cis_pkg::EVT_W-1:0] evtStat, evtMask;
   logic wrAcc, setup, hit;
   logic [7:0] irqCtrlView;
   logic request, wakeReq, enterNow, startEntry;

   function automatic logic regWrite(input logic [7:0] off);
      regWrite = wrAcc && (paddr == off);
   endfunction : regWrite

   // -------------------------------------------------------------------
   // instruction phase counter
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         phase <= cis_pkg::PHASE_Q1;
      end else begin
         phase <= phase + 2'h1;
      end
   end
   assign q1 = (phase == cis_pkg::PHASE_Q1);
   assign instrPhase = phase;

   // -------------------------------------------------------------------
   // external pin synchroniser and edge detect
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         extSync1 <= 1'b0;
         extSync2 <= 1'b0;
         extPrev <= 1'b0;
      end else begin
         extSync1 <= extPin;
         extSync2 <= extSync1;
         extPrev <= extSync2;
      end
   end
   // rising when select is one, falling when zero
   assign extEdge = extEdgeSelect ? (extSync2 && !extPrev)
                                  : (!extSync2 && extPrev);

   // -------------------------------------------------------------------
   // apb decode
   // -------------------------------------------------------------------
   assign setup = psel && !penable;
   assign wrAcc = psel && penable && pwrite;
   assign pready = 1'b1;
   assign hit = (paddr == cis_pkg::OFF_IRQ_CTRL)
             || (paddr == cis_pkg::OFF_PER_EN)
             || (paddr == cis_pkg::OFF_PER_FLAG)
             || (paddr == cis_pkg::OFF_EDGE)
             || (paddr == cis_pkg::OFF_SEQ_STAT)
             || (paddr == cis_pkg::OFF_EVT_STAT)
             || (paddr == cis_pkg::OFF_EVT_MASK);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= !hit;
      end
   end

   assign irqCtrlView = {global_irq_enable, peripheral_group_enable, tmrEn, extEn, iocEn,
                         tmrFlag, extFlag, iocFlag};

   // read data captured in setup, held through access
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         case (paddr)
            cis_pkg::OFF_IRQ_CTRL: prdata <= {24'h00_0000, irqCtrlView};
            cis_pkg::OFF_PER_EN: prdata <= 32'(perEn);
            cis_pkg::OFF_PER_FLAG: prdata <= 32'(perFlag);
            cis_pkg::OFF_EDGE: prdata <= {31'h0, extEdgeSelect};
            cis_pkg::OFF_SEQ_STAT: prdata <= {26'h000_0000, wakeHold,
                                              coreSleep, 2'(state), phase};
            cis_pkg::OFF_EVT_STAT: prdata <= 32'(evtStat);
            cis_pkg::OFF_EVT_MASK: prdata <= 32'(evtMask);
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // enables and edge select
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         peripheral_group_enable <= cis_pkg::IRQ_CTRL_RST[cis_pkg::B_PERIPHERAL_GROUP_ENABLE];
         tmrEn <= cis_pkg::IRQ_CTRL_RST[cis_pkg::B_TMR_EN];
         extEn <= cis_pkg::IRQ_CTRL_RST[cis_pkg::B_EXT_EN];
         iocEn <= cis_pkg::IRQ_CTRL_RST[cis_pkg::B_IOC_EN];
         perEn <= '0;
         extEdgeSelect <= 1'b0;
      end else begin
         if (regWrite(cis_pkg::OFF_IRQ_CTRL)) begin
            peripheral_group_enable <= pwdata[cis_pkg::B_PERIPHERAL_GROUP_ENABLE];
            tmrEn <= pwdata[cis_pkg::B_TMR_EN];
            extEn <= pwdata[cis_pkg::B_EXT_EN];
            iocEn <= pwdata[cis_pkg::B_IOC_EN];
         end
         if (regWrite(cis_pkg::OFF_PER_EN)) begin
            perEn <= pwdata[NPER-1:0];
         end
         if (regWrite(cis_pkg::OFF_EDGE)) begin
            extEdgeSelect <= pwdata[0];
         end
      end
   end

   // global enable: reset clears, entry clears, return sets
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         global_irq_enable <= cis_pkg::IRQ_CTRL_RST[cis_pkg::B_GIE];
      end else if (returnFromIrq) begin
         global_irq_enable <= 1'b1;
      end else if (enterNow) begin
         global_irq_enable <= 1'b0;
      end else if (regWrite(cis_pkg::OFF_IRQ_CTRL)) begin
         global_irq_enable <= pwdata[cis_pkg::B_GIE];
      end
   end

   // -------------------------------------------------------------------
   // flags: timer, ext and peripheral set by events whatever the enables, event beats clear; ioc flag follows iocAny
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tmrFlag <= 1'b0;
         extFlag <= 1'b0;
         iocFlag <= 1'b0;
         perFlag <= '0;
      end else begin
         iocFlag <= iocAny;
         if (timerEvent) begin
            tmrFlag <= 1'b1;
         end else if (regWrite(cis_pkg::OFF_IRQ_CTRL)) begin
            tmrFlag <= pwdata[cis_pkg::B_TMR_FLAG];
         end
         if (extEdge) begin
            extFlag <= 1'b1;
         end else if (regWrite(cis_pkg::OFF_IRQ_CTRL)) begin
            extFlag <= pwdata[cis_pkg::B_EXT_FLAG];
         end
         if (regWrite(cis_pkg::OFF_PER_FLAG)) begin
            perFlag <= pwdata[NPER-1:0] | perEvent;
         end else begin
            perFlag <= perFlag | perEvent;
         end
      end
   end

   // -------------------------------------------------------------------
   // request and wake terms
   // -------------------------------------------------------------------
   assign request = global_irq_enable && ((tmrFlag && tmrEn) || (extFlag && extEn)
                   || (iocFlag && iocEn)
                   || (peripheral_group_enable && |(perFlag & perEn)));
   // only enables held at sleep entry, only clockless-capable sources
   assign wakeReq = (extFlag && slpEn[1]) || (iocFlag && slpEn[0])
                 || |(perFlag & slpPerEn & PER_WAKE_OK);
   // sampled once per cycle at Q1, so ext flag set Q4-Q1 is seen
   assign startEntry = (state == cis_pkg::ST_RUN) && q1 && !coreSleep
                    && !wakeHold && request;
   assign enterNow = (state == cis_pkg::ST_FLUSH) && q1;

   // -------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= cis_pkg::ST_RUN;
      end else begin
         case (state)
            cis_pkg::ST_RUN: begin
               // stale sleep level in the clock after wake is ignored
               if (q1 && coreSleep && !wakeHold) begin
                  state <= cis_pkg::ST_SLEEP;
               end else if (startEntry) begin
                  state <= cis_pkg::ST_FLUSH;
               end
            end
            cis_pkg::ST_FLUSH: begin
               if (q1) begin
                  state <= cis_pkg::ST_ENTER;
               end
            end
            cis_pkg::ST_ENTER: begin
               if (q1) begin
                  state <= cis_pkg::ST_RUN;
               end
            end
            cis_pkg::ST_SLEEP: begin
               if (wakeReq || !coreSleep) begin
                  state <= cis_pkg::ST_RUN;
               end
            end
            default: state <= cis_pkg::ST_RUN;
         endcase
      end
   end

   // enables captured on the way into sleep
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         slpEn <= 3'h0;
         slpPerEn <= '0;
      end else if (state == cis_pkg::ST_RUN && q1 && coreSleep
                   && !wakeHold) begin
         slpEn <= {tmrEn, extEn, iocEn};
         slpPerEn <= perEn & {NPER{peripheral_group_enable}};
      end
   end

   // skip the first Q1 after wake so the next instruction runs
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wakeHold <= 1'b0;
      end else if (state == cis_pkg::ST_SLEEP && wakeReq) begin
         wakeHold <= 1'b1;
      end else if (q1) begin
         wakeHold <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // core strobes, one clock wide
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flushPrefetch <= 1'b0;
         pushPc <= 1'b0;
         pushAddr <= '0;
         loadVector <= 1'b0;
         vectorAddr <= '0;
         popPc <= 1'b0;
         restoreCtx <= 1'b0;
         wakeUp <= 1'b0;
      end else begin
         flushPrefetch <= startEntry;
         pushPc <= enterNow;
         loadVector <= enterNow;
         if (enterNow) begin
            pushAddr <= corePc;
            vectorAddr <= cis_pkg::IRQ_VECTOR;
         end
         popPc <= returnFromIrq;
         restoreCtx <= returnFromIrq;
         wakeUp <= (state == cis_pkg::ST_SLEEP) && wakeReq;
      end
   end

   // -------------------------------------------------------------------
   // context shadow
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         shadowW <= '0;
         shadowStatus <= '0;
         shadowBsr <= '0;
         shadowFsr0 <= '0;
         shadowFsr1 <= '0;
         shadowPclath <= '0;
      end else if (enterNow) begin
         shadowW <= ctxW;
         shadowStatus <= ctxStatus;
         shadowBsr <= ctxBsr;
         shadowFsr0 <= ctxFsr0;
         shadowFsr1 <= ctxFsr1;
         shadowPclath <= ctxPclath;
      end
   end

   // -------------------------------------------------------------------
   // sequencer event status, mask and interrupt line
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         evtMask <= '0;
      end else if (regWrite(cis_pkg::OFF_EVT_MASK)) begin
         evtMask <= pwdata[cis_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         evtStat <= '0;
      end else begin
         // write one clears, a new event in the same cycle wins
         evtStat <= (regWrite(cis_pkg::OFF_EVT_STAT)
                     ? (evtStat & ~pwdata[cis_pkg::EVT_W-1:0]) : evtStat)
                  | {(state == cis_pkg::ST_SLEEP) && wakeReq,
                     returnFromIrq, enterNow};
      end
   end

   assign irq = |(evtStat & evtMask);
endmodule : cis_sequencer

// *** logic/cis_pkg.sv ***
// constants for the interrupt sequencer: register map, fields, widths
// assumes a 32-bit apb bus and a four-phase instruction cycle
package cis_pkg;
   // -------------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] OFF_IRQ_CTRL = 8'h00;
   localparam logic [7:0] OFF_PER_EN = 8'h04;
   localparam logic [7:0] OFF_PER_FLAG = 8'h08;
   localparam logic [7:0] OFF_EDGE = 8'h0c;
   localparam logic [7:0] OFF_SEQ_STAT = 8'h10;
   localparam logic [7:0] OFF_EVT_STAT = 8'h14;
   localparam logic [7:0] OFF_EVT_MASK = 8'h18;
   // -------------------------------------------------------------------
   // irq_control_reg fields
   // -------------------------------------------------------------------
   localparam int B_GIE = 7;
   localparam int B_PERIPHERAL_GROUP_ENABLE = 6;
   localparam int B_TMR_EN = 5;
   localparam int B_EXT_EN = 4;
   localparam int B_IOC_EN = 3;
   localparam int B_TMR_FLAG = 2;
   localparam int B_EXT_FLAG = 1;
   localparam int B_IOC_FLAG = 0;
   // event status / mask fields
   localparam int B_EVT_ENTRY = 0;
   localparam int B_EVT_RETURN = 1;
   localparam int B_EVT_WAKE = 2;
   localparam int EVT_W = 3;
   // -------------------------------------------------------------------
   // reset values, vector, widths
   // -------------------------------------------------------------------
   localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
   localparam logic [14:0] IRQ_VECTOR = 15'h0004;
   localparam int PC_W = 15;
   localparam int W_W = 8;
   localparam int STAT_W = 3;
   localparam int BSR_W = 5;
   localparam int FSR_W = 16;
   localparam int PCLATH_W = 7;
   localparam logic [1:0] PHASE_Q1 = 2'h0;
   localparam logic [1:0] PHASE_Q4 = 2'h3;
   // -------------------------------------------------------------------
   // sequencer states
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_FLUSH = 2'b01,
      ST_ENTER = 2'b10,
      ST_SLEEP = 2'b11
   } cis_state_t;
endpackage : cis_pkg

// *** testbench/cis_sequencer_monitor.sv ***
// checker for the interrupt sequencer, bound to its top module
// assumes one clock domain, clk_sys, and active-low resetn
`timescale 1ns/100ps
module cis_sequencer_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic returnFromIrq,
   input wire logic [14:0] corePc,
   input wire logic [7:0] ctxW,
   input wire logic [2:0] ctxStatus,
   input wire logic [4:0] ctxBsr,
   input wire logic [15:0] ctxFsr0,
   input wire logic [15:0] ctxFsr1,
   input wire logic [6:0] ctxPclath,
   input wire logic [1:0] instrPhase,
   input wire logic flushPrefetch,
   input wire logic pushPc,
   input wire logic [14:0] pushAddr,
   input wire logic loadVector,
   input wire logic [14:0] vectorAddr,
   input wire logic popPc,
   input wire logic restoreCtx,
   input wire logic wakeUp,
   input wire logic [7:0] shadowW,
   input wire logic [2:0] shadowStatus,
   input wire logic [4:0] shadowBsr,
   input wire logic [15:0] shadowFsr0,
   input wire logic [15:0] shadowFsr1,
   input wire logic [6:0] shadowPclath
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   vec_value_a: assert property (
      loadVector |-> vectorAddr == cis_pkg::IRQ_VECTOR)
      else $error("vector address wrong");
   push_pair_a: assert property (pushPc == loadVector)
      else $error("push and vector load apart");
   entry_span_a: assert property (
      flushPrefetch |-> ##4 (pushPc && loadVector))
      else $error("push not four clocks after flush");
   push_cause_a: assert property (
      pushPc |-> $past(flushPrefetch, 4))
      else $error("push without flush");
   ctx_save_a: assert property (pushPc |->
      pushAddr == $past(corePc) && shadowW == $past(ctxW)
      && shadowStatus == $past(ctxStatus) && shadowBsr == $past(ctxBsr)
      && shadowFsr0 == $past(ctxFsr0) && shadowFsr1 == $past(ctxFsr1)
      && shadowPclath == $past(ctxPclath))
      else $error("context not saved at push");
   ret_pop_a: assert property (
      returnFromIrq |=> popPc && restoreCtx)
      else $error("return did not pop");
   pop_cause_a: assert property (popPc |-> $past(returnFromIrq))
      else $error("pop without return");
   // first clock after reset release has no stepped predecessor
   phase_step_a: assert property ($past(resetn) |->
      instrPhase == $past(instrPhase) + 2'h1)
      else $error("phase not stepping");
   flush_gap_a: assert property (
      flushPrefetch |=> !flushPrefetch [*8])
      else $error("entry restarted during service");
   rst_quiet_a: assert property (
      $rose(resetn) |-> !flushPrefetch [*8])
      else $error("entry right after reset");
   cover property (flushPrefetch);
   cover property (popPc);
   cover property (wakeUp);
endmodule : cis_sequencer_monitor

bind cis_sequencer cis_sequencer_monitor u_cis_sequencer_monitor (.*);

// *** testbench/cis_core_model.sv ***
// behavioural core: program counter, live context, sleep and return
// assumes sequencer outputs on clk_sys; bench requests sleep and return
`timescale 1ns/100ps
module cis_core_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic retReq,
   input wire logic sleepReq,
   input wire logic wakeUp,
   input wire logic loadVector,
   output logic coreSleep,
   output logic returnFromIrq,
   output logic [14:0] corePc,
   output logic [7:0] ctxW,
   output logic [2:0] ctxStatus,
   output logic [4:0] ctxBsr,
   output logic [15:0] ctxFsr0,
   output logic [15:0] ctxFsr1,
   output logic [6:0] ctxPclath
);
   logic sleepQ;
   // context follows the pc so every save is distinct
   assign ctxW = corePc[7:0] ^ 8'h5a;
   assign ctxStatus = corePc[2:0];
   assign ctxBsr = corePc[4:0];
   assign ctxFsr0 = {1'b0, corePc};
   assign ctxFsr1 = ~{1'b0, corePc};
   assign ctxPclath = corePc[14:8];
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         corePc <= '0;
         coreSleep <= 1'b0;
         sleepQ <= 1'b0;
         returnFromIrq <= 1'b0;
      end else begin
         sleepQ <= sleepReq;
         returnFromIrq <= retReq;
         if (loadVector)
            corePc <= cis_pkg::IRQ_VECTOR;
         else if (!coreSleep)
            corePc <= corePc + 15'h0001;
         if (wakeUp || !sleepReq)
            coreSleep <= 1'b0;
         else if (!sleepQ)
            coreSleep <= 1'b1;
      end
   end
endmodule : cis_core_model

// *** testbench/testbench.sv ***
// self-checking bench: apb register calls, event pulses, sleep and return
// assumes the sequencer and core model share clk_sys at 40 MHz
`timescale 1ns/100ps
module testbench;
   logic clk_sys = 1'b0;
   logic resetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr, perEvent, ctxW, shadowW;
   logic [31:0] pwdata, prdata, r;
   logic timerEvent, iocAny, extPin, coreSleep, returnFromIrq;
   logic retReq, sleepReq, e, extQ;
   logic [14:0] corePc, pushAddr, vectorAddr;
   logic [2:0] ctxStatus, shadowStatus;
   logic [4:0] ctxBsr, shadowBsr;
   logic [15:0] ctxFsr0, ctxFsr1, shadowFsr0, shadowFsr1;
   logic [6:0] ctxPclath, shadowPclath;
   logic [1:0] instrPhase;
   logic flushPrefetch, pushPc, loadVector, popPc, restoreCtx, wakeUp;
   int checks = 0, error_cnt = 0, cyc = 0, nFl = 0, nVec = 0, nWk = 0;
   int tFl, tVec, tWk, tEv, lo, hi, n0;
   always #12.5 clk_sys = ~clk_sys;
   cis_sequencer u_cis_sequencer (.*);
   cis_core_model u_cis_core_model (.*);
   // -------------------------------------------------------------------
   // event counters and time stamps
   // -------------------------------------------------------------------
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      extQ <= extPin;
      if (timerEvent === 1'b1 || extPin !== extQ)
         tEv <= cyc;
      if (flushPrefetch === 1'b1) begin
         nFl <= nFl + 1;
         tFl <= cyc;
      end
      if (loadVector === 1'b1) begin
         nVec <= nVec + 1;
         tVec <= cyc;
      end
      if (wakeUp === 1'b1) begin
         nWk <= nWk + 1;
         tWk <= cyc;
      end
   end
   task automatic close_out;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic chk(input string n, input logic [31:0] x,
                      input logic [31:0] g);
      checks++;
      if (g !== x) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("register read", x, r);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle
   // waits on flush (0), vector (1) or wake (2) count
   task automatic wt(input int w, input int v);
      for (int n = 0; n < 99 && (w == 0 ? nFl : w == 1 ? nVec : nWk) < v; n++)
         @(posedge clk_sys);
      chk("event count", v, w == 0 ? nFl : w == 1 ? nVec : nWk);
   endtask : wt
   task automatic ret;
      @(posedge clk_sys);
      retReq <= 1'b1;
      @(posedge clk_sys);
      retReq <= 1'b0;
      idle(4);
   endtask : ret
   initial begin
      #(25 * 20000);
      error_cnt++;
      close_out();
   end
   // -------------------------------------------------------------------
   // test sequence
   // -------------------------------------------------------------------
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {timerEvent, iocAny, extPin, perEvent, retReq, sleepReq} = '0;
      idle(2);
      resetn <= 1'b1;
      rd(cis_pkg::OFF_IRQ_CTRL, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      wr(cis_pkg::OFF_PER_EN, 32'h1);
      wr(cis_pkg::OFF_IRQ_CTRL, 32'h20);
      timerEvent <= 1'b1;
      @(posedge clk_sys) timerEvent <= 1'b0;
      idle(16);
      chk("no entry", 0, nFl);
      rd(cis_pkg::OFF_IRQ_CTRL, 32'h24);
      wr(cis_pkg::OFF_IRQ_CTRL, 32'ha4);
      wt(1, 1);
      rd(cis_pkg::OFF_IRQ_CTRL, 32'h24);
      chk("vector", 32'h4, {17'h0, vectorAddr});
      perEvent <= 8'h01;
      @(posedge clk_sys) perEvent <= 8'h00;
      idle(16);
      chk("no entry in service", 1, nFl);
      rd(cis_pkg::OFF_PER_FLAG, 32'h1);
      wr(cis_pkg::OFF_IRQ_CTRL, 32'h20);
      ret();
      rd(cis_pkg::OFF_IRQ_CTRL, 32'ha0);
      idle(16);
      chk("group gate", 1, nFl);
      chk("irq masked", 0, irq);
      wr(cis_pkg::OFF_EVT_MASK, 32'h3);
      idle(1);
      chk("irq raised", 1, irq);
      rd(cis_pkg::OFF_EVT_STAT, 32'h3);
      wr(cis_pkg::OFF_EVT_STAT, 32'h1);
      rd(cis_pkg::OFF_EVT_STAT, 32'h2);
      wr(cis_pkg::OFF_EVT_STAT, 32'h2);
      idle(1);
      chk("irq cleared", 0, irq);
      wr(cis_pkg::OFF_IRQ_CTRL, 32'he0);
      wt(0, 2);
      wr(cis_pkg::OFF_PER_FLAG, 32'h0);
      ret();
      idle(16);
      chk("no repeat", 2, nFl);
      wr(cis_pkg::OFF_EDGE, 32'h1);
      for (int s = 0; s < 2; s++) begin
         lo = 99;
         hi = 0;
         for (int k = 0; k < 4; k++) begin
            wr(cis_pkg::OFF_IRQ_CTRL, s ? 32'h90 : 32'ha0);
            idle(k + 1);
            if (s)
               extPin <= 1'b1;
            else
               timerEvent <= 1'b1;
            @(posedge clk_sys) timerEvent <= 1'b0;
            wt(1, nVec + 1);
            lo = (tVec - tEv < lo) ? tVec - tEv : lo;
            hi = (tVec - tEv > hi) ? tVec - tEv : hi;
            extPin <= 1'b0;
            wr(cis_pkg::OFF_IRQ_CTRL, s ? 32'h10 : 32'h20);
            ret();
         end
         chk("latency spread", 1, hi - lo <= (s ? 8 : 4));
         chk("latency bound", 1, hi <= 20 && lo >= 4);
      end
      wr(cis_pkg::OFF_EDGE, 32'h0);
      wr(cis_pkg::OFF_IRQ_CTRL, 32'h0);
      extPin <= 1'b1;
      idle(6);
      rd(cis_pkg::OFF_IRQ_CTRL, 32'h0);
      extPin <= 1'b0;
      idle(6);
      rd(cis_pkg::OFF_IRQ_CTRL, 32'h2);
      wr(cis_pkg::OFF_IRQ_CTRL, 32'h20);
      sleepReq <= 1'b1;
      idle(8);
      timerEvent <= 1'b1;
      @(posedge clk_sys) timerEvent <= 1'b0;
      idle(12);
      chk("timer no wake", 0, nWk);
      wr(cis_pkg::OFF_IRQ_CTRL, 32'h28);
      iocAny <= 1'b1;
      idle(12);
      chk("late enable no wake", 0, nWk);
      iocAny <= 1'b0;
      sleepReq <= 1'b0;
      idle(8);
      for (int g = 0; g < 2; g++) begin
         n0 = nFl;
         wr(cis_pkg::OFF_IRQ_CTRL, g ? 32'h88 : 32'h08);
         sleepReq <= 1'b1;
         idle(8);
         iocAny <= 1'b1;
         wt(2, g + 1);
         sleepReq <= 1'b0;
         idle(20);
         chk("wake branch", n0 + g, nFl);
         if (g)
            chk("after sleep first", 1, tFl - tWk >= 4);
         iocAny <= 1'b0;
         idle(4);
         if (g)
            ret();
      end
      rd(cis_pkg::OFF_EVT_STAT, 32'h7);
      // reset in mid-run with the global enable set
      wr(cis_pkg::OFF_IRQ_CTRL, 32'ha8);
      resetn <= 1'b0;
      idle(2);
      resetn <= 1'b1;
      rd(cis_pkg::OFF_IRQ_CTRL, 32'h0);
      chk("irq after reset", 0, irq);
      close_out();
   end
endmodule : testbench
